// ---- bench/sasp_host.sv ----
// Host controller model: drives frames and the start pin of the port.
// Assumes core_clk is the bench clock; serial phases are counted in its cycles.
`timescale 1ns/1ps
module sasp_host (
  // Clock
  input wire logic core_clk,
  // Serial bus
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_line,
  // Start pin
  output logic conversion_start_n
);
  // Six cycles high and seven low keep the period far inside the 1000 ns ceiling
  localparam int HALF = 6;

  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    conversion_start_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame with nrise rising edges; reads only while no conversion runs
  // ----------------------------------------------------------------
  // Ends after the 5th or 17th rise for whole commands
  task automatic frame(input int nrise, input logic [15:0] cmd, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge core_clk) chip_select_n <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (int i = 0; i < nrise; i++) begin
      if (i < nrise - 1) serial_in <= cmd[nrise-2-i];
      @(posedge core_clk) serial_clk <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      if (i < nrise - 1) begin
        rx = {rx[14:0], serial_line};
        serial_clk <= 1'b0;
      end
      repeat (HALF) @(posedge core_clk);
    end
    @(posedge core_clk) chip_select_n <= 1'b1;
    repeat (HALF) @(posedge core_clk);
    // Clock returns to idle while deselected; data line no longer holds its bit
    serial_clk <= 1'b0;
    serial_in <= ~serial_in;
    repeat (HALF) @(posedge core_clk);
  endtask

  // Start pulse held 40 ns, exactly the minimum, so the filter edge is exercised
  task automatic start_pulse();
    @(posedge core_clk) conversion_start_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    conversion_start_n <= 1'b1;
  endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench of the converter serial port with a host model.
// Assumes the package constants and the hand-over latencies of the port.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import sasp_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_conv_clk_sel = 1'b0;
  logic [RESULT_W-1:0] analog_code = '0;
  wire chip_select_n, serial_clk, serial_in, conversion_start_n;
  logic serial_out, serial_out_oe, conversion_done_n, sampling_done;
  logic interrupt_out_n, conv_clock, cmd_valid, cmd_long;
  logic [CMD_W-1:0] cmd_data;
  logic [15:0] rx;
  logic prev_cc = 1'b0;
  logic [RESULT_W-1:0] codes[$];
  int mismatches = 0;
  int n_tests = 0;
  int nval = 0;
  int ntog = 0;
  int t;
  // Released output has no pull: the line shows the inverse, so a late read is caught
  wire serial_line = serial_out_oe ? serial_out : ~serial_out;

  always #5 core_clk = ~core_clk;

  sasp_host host (.core_clk(core_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_line(serial_line), .conversion_start_n(conversion_start_n));

  sasp_port dut (.core_clk(core_clk), .rstn(rstn), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .conversion_start_n(conversion_start_n),
    .conversion_done_n(conversion_done_n), .sampling_done(sampling_done),
    .interrupt_out_n(interrupt_out_n), .conv_clock(conv_clock), .ext_conv_clk_sel(ext_conv_clk_sel),
    .analog_code(analog_code), .cmd_valid(cmd_valid), .cmd_long(cmd_long), .cmd_data(cmd_data));

  // Monitors: command pulses, conversion clock toggles, status pair
  always @(posedge core_clk) begin
    if (rstn && cmd_valid === 1'b1) nval++;
    if (conv_clock !== prev_cc) ntog++;
    prev_cc <= conv_clock;
    if (rstn) `CHK(sampling_done, ~conversion_done_n)
  end

  // Bits read are the top nrise-1 of the result followed by zeros
  function automatic logic [15:0] exp_rx(input logic [RESULT_W-1:0] c, input int nrise);
    return {c, 2'b00} >> (17 - nrise);
  endfunction

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic convert();
    logic [RESULT_W-1:0] c;
    int k;
    c = RESULT_W'($urandom);
    codes.push_back(c);
    @(posedge core_clk) analog_code <= c;
    host.start_pulse();
    // Wait for the conversion to start before waiting for its end
    k = 0;
    while (conversion_done_n !== 1'b1 && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    `CHK(conversion_done_n, 1'b1)
    k = 0;
    while (conversion_done_n !== 1'b0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    `CHK(conversion_done_n, 1'b0)
    repeat (3) @(posedge core_clk);
    `CHK(interrupt_out_n, 1'b0)
  endtask

  task automatic rd(input int nrise, input logic [RESULT_W-1:0] c);
    logic [15:0] cmd;
    int v;
    bit ok;
    cmd = 16'($urandom);
    v = nval;
    ok = (nrise == 5 || nrise == 17);
    host.frame(nrise, cmd, rx);
    repeat (6) @(posedge core_clk);
    `CHK(rx, exp_rx(c, nrise))
    `CHK(serial_out_oe, 1'b0)
    `CHK(nval, v + int'(ok))
    if (nrise == 17) `CHK(cmd_data, cmd)
    if (nrise == 5) `CHK(cmd_data, {12'h000, cmd[3:0]})
    if (ok) `CHK(cmd_long, nrise == 17)
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK(interrupt_out_n, 1'b1)
    `CHK(serial_out_oe, 1'b0)
    // Fill the FIFO while the host stalls, then drain it in order
    repeat (4) convert();
    rd(17, codes.pop_front());
    `CHK(interrupt_out_n, 1'b1)
    rd(5, codes.pop_front());
    rd(3, codes.pop_front());
    rd(17, codes.pop_front());
    rd(17, 14'h0000);
    // Random traffic, short and long commands
    repeat (4) begin
      convert();
      rd(($urandom % 2) ? 17 : 5, codes.pop_front());
    end
    // Conversion clock from the serial clock: one toggle per rise
    @(posedge core_clk) ext_conv_clk_sel <= 1'b1;
    repeat (4) @(posedge core_clk);
    t = ntog;
    rd(17, 14'h0000);
    `CHK(ntog - t, 17)
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule

// ---- logic/sasp_fifo.sv ----
// Small result FIFO between the conversion sequencer and the serial shifter.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/1ps
module sasp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Storage has no reset; only the pointers and the count need a defined state
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- logic/sasp_pkg.sv ----
// Package of the converter serial port: widths, timing counts and state codes.
// Assumes a single core clock of 100 MHz; the core-cycle counts are derived from it.
package sasp_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 100;
  localparam int CONVST_MIN_NS = 40;
  localparam int CONVST_MIN_CYC = (CONVST_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int INT_CONV_CLOCK_KHZ = 21000;
  localparam int INT_HALF_CYC_RAW = (CORE_CLK_MHZ * 1000) / (2 * INT_CONV_CLOCK_KHZ);
  localparam int INT_HALF_CYC = (INT_HALF_CYC_RAW < 1) ? 1 : INT_HALF_CYC_RAW;
  localparam int CONV_TICKS = 18;

  // ----------------------------------------------------------------
  // Data and frame layout
  // ----------------------------------------------------------------
  localparam int RESULT_W = 14;
  localparam int CMD_W = 16;
  localparam int CMD_SHORT_BITS = 4;
  localparam int CMD_LONG_BITS = 16;
  localparam int CMD_SHORT_RISES = 5;
  localparam int CMD_LONG_RISES = 17;
  localparam int CNT_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SASP_SAMPLE = 3'b001,
    SASP_CONVERT = 3'b010,
    SASP_STORE = 3'b100
  } sasp_state_type;
endpackage

// ---- logic/sasp_port.sv ----
// Serial host port of a multichannel successive-approximation converter.
// Assumes all pins are asynchronous to core_clk and are synchronised here;
// the serial clock is slow enough to be sampled (at least 4 core cycles/phase).
`timescale 1ns/1ps
module sasp_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial bus pins
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Conversion control pins
  input wire logic conversion_start_n,
  output logic conversion_done_n,
  output logic sampling_done,
  output logic interrupt_out_n,
  output logic conv_clock,
  // Analog core side
  input wire logic ext_conv_clk_sel,
  input wire logic [sasp_pkg::RESULT_W-1:0] analog_code,
  // Received commands
  output logic cmd_valid,
  output logic cmd_long,
  output logic [sasp_pkg::CMD_W-1:0] cmd_data
);
  import sasp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic cs_d_r;
  logic sclk_d_r;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_r <= 4'h9; // Idle levels, so no false sclk edge follows reset
      pin_s2_r <= 4'h9;
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {conversion_start_n, serial_in, serial_clk, chip_select_n};
      pin_s2_r <= pin_s1_r;
      cs_d_r <= pin_s2_r[0];
      sclk_d_r <= pin_s2_r[1];
    end
  end

  wire cs_n_s = pin_s2_r[0];
  wire sclk_s = pin_s2_r[1];
  wire sdi_s = pin_s2_r[2];
  wire convst_n_s = pin_s2_r[3];
  wire cs_fall = cs_d_r && !cs_n_s;
  wire cs_rise = !cs_d_r && cs_n_s;
  wire cs_act = !cs_n_s && !cs_fall;
  wire sclk_rise = !sclk_d_r && sclk_s;
  wire sclk_fall = sclk_d_r && !sclk_s;

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_r;
  logic conv_clock_r;
  wire div_done = (div_cnt_r == 8'(INT_HALF_CYC - 1));
  // Each serial rising edge toggles, giving half the serial rate
  wire conv_clock_toggle = ext_conv_clk_sel ? sclk_rise : div_done;
  wire conv_clock_tick = conv_clock_toggle && !conv_clock_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_cnt_r <= 8'h00;
      conv_clock_r <= 1'b0;
    end else begin
      div_cnt_r <= div_done ? 8'h00 : div_cnt_r + 8'h01;
      if (conv_clock_toggle) begin
        conv_clock_r <= !conv_clock_r;
      end
    end
  end
  assign conv_clock = conv_clock_r;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sasp_state_type state_r;
  sasp_state_type state_nxt;
  logic [7:0] low_cnt_r;
  logic [4:0] tick_cnt_r;
  logic busy_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [RESULT_W-1:0] fifo_out_data;
  // A start pulse counts once it has stayed low long enough; the current low cycle is the last one counted
  wire start_ok = (low_cnt_r == 8'(CONVST_MIN_CYC - 1)) && !convst_n_s;
  wire conv_end = (tick_cnt_r == 5'(CONV_TICKS - 1)) && conv_clock_tick;
  // A full FIFO holds the sequencer in STORE, stalling the next sample
  wire push = (state_r == SASP_STORE) && fifo_in_ready;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SASP_SAMPLE: begin
        if (start_ok) begin
          state_nxt = SASP_CONVERT;
        end
      end
      SASP_CONVERT: begin
        if (conv_end) begin
          state_nxt = SASP_STORE;
        end
      end
      SASP_STORE: begin
        if (fifo_in_ready) begin
          state_nxt = SASP_SAMPLE;
        end
      end
      default: state_nxt = SASP_SAMPLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= SASP_SAMPLE;
      low_cnt_r <= 8'h00;
      tick_cnt_r <= 5'h00;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (convst_n_s || state_r != SASP_SAMPLE) begin
        low_cnt_r <= 8'h00;
      end else if (low_cnt_r != 8'(CONVST_MIN_CYC)) begin
        low_cnt_r <= low_cnt_r + 8'h01;
      end
      if (state_r != SASP_CONVERT) begin
        tick_cnt_r <= 5'h00;
      end else if (conv_clock_tick) begin
        tick_cnt_r <= tick_cnt_r + 5'h01;
      end
      busy_r <= (state_nxt == SASP_CONVERT);
    end
  end

  // One flop drives both, so they can never disagree
  assign conversion_done_n = busy_r;
  assign sampling_done = !busy_r;

  sasp_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(state_r == SASP_STORE),
    .in_ready(fifo_in_ready),
    .in_data(analog_code),
    .out_valid(fifo_out_valid),
    .out_ready(cs_fall),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Serial shifter and interrupt
  // ----------------------------------------------------------------
  logic [RESULT_W-1:0] tx_r;
  logic [CMD_W-1:0] rx_r;
  logic [CNT_W-1:0] fall_cnt_r;
  logic [CNT_W-1:0] rise_cnt_r;
  logic sdo_r;
  logic sdo_oe_r;
  logic int_n_r;
  logic cmd_valid_r;
  logic cmd_long_r;
  logic [CMD_W-1:0] cmd_data_r;
  // An empty FIFO repeats nothing stale: it sends zeros
  wire [RESULT_W-1:0] load_word = fifo_out_valid ? fifo_out_data : '0;
  wire short_cmd = (rise_cnt_r == CNT_W'(CMD_SHORT_RISES));
  wire long_cmd = (rise_cnt_r == CNT_W'(CMD_LONG_RISES));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_r <= '0;
      rx_r <= CMD_RESET;
      fall_cnt_r <= '0;
      rise_cnt_r <= '0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (cs_fall) begin
      tx_r <= {load_word[RESULT_W-2:0], 1'b0};
      sdo_r <= load_word[RESULT_W-1];
      sdo_oe_r <= 1'b1;
      fall_cnt_r <= '0;
      rise_cnt_r <= '0;
    end else if (cs_act) begin
      if (sclk_fall) begin
        rx_r <= {rx_r[CMD_W-2:0], sdi_s};
        sdo_r <= tx_r[RESULT_W-1];
        tx_r <= {tx_r[RESULT_W-2:0], 1'b0};
        if (fall_cnt_r != '1) begin
          fall_cnt_r <= fall_cnt_r + 1'b1;
        end
      end
      if (sclk_rise && rise_cnt_r != '1) begin
        rise_cnt_r <= rise_cnt_r + 1'b1;
      end
    end else begin
      sdo_oe_r <= 1'b0;
    end
  end

  // A frame ending after the 5th or 17th rising edge carries a command
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_valid_r <= 1'b0;
      cmd_long_r <= 1'b0;
      cmd_data_r <= CMD_RESET;
    end else begin
      cmd_valid_r <= cs_rise && (short_cmd || long_cmd);
      if (cs_rise && short_cmd) begin
        cmd_long_r <= 1'b0;
        cmd_data_r <= {12'h000, rx_r[CMD_SHORT_BITS-1:0]};
      end else if (cs_rise && long_cmd) begin
        cmd_long_r <= 1'b1;
        cmd_data_r <= rx_r[CMD_LONG_BITS-1:0];
      end
    end
  end

  // A new result sets the interrupt; it wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      int_n_r <= 1'b1;
    end else if (push) begin
      int_n_r <= 1'b0;
    end else if (cs_fall) begin
      int_n_r <= 1'b1;
    end
  end

  assign serial_out = sdo_r;
  assign serial_out_oe = sdo_oe_r;
  assign interrupt_out_n = int_n_r;
  assign cmd_valid = cmd_valid_r;
  assign cmd_long = cmd_long_r;
  assign cmd_data = cmd_data_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_eos_complement: assert property (@(posedge core_clk) disable iff (!rstn)
    sampling_done == !conversion_done_n && conversion_done_n == (state_r == SASP_CONVERT))
    else $error("end flags not complementary");
  a_half_rate: assert property (@(posedge core_clk) disable iff (!rstn)
    ext_conv_clk_sel && sclk_rise |=> conv_clock != $past(conv_clock)) else $error("conv_clock not toggled");
  a_conv_clock_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    ext_conv_clk_sel && !sclk_rise |=> $stable(conv_clock)) else $error("conv_clock moved without sclk");
  a_sdi_sample: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_act && sclk_fall |=> rx_r[0] == $past(sdi_s)) else $error("serial input not sampled");
  a_sdo_shift: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_act && sclk_fall |=> serial_out == $past(tx_r[RESULT_W-1])) else $error("serial output not advanced");
  a_msb_first: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_fall |=> serial_out_oe && serial_out == $past(load_word[RESULT_W-1])) else $error("msb not presented");
  a_sdo_release: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_n_s && !cs_fall |=> !serial_out_oe) else $error("output driven while deselected");
  a_int_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_fall && !push |=> interrupt_out_n) else $error("interrupt not cleared");
  a_count_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    cs_fall |=> fall_cnt_r == '0 && rise_cnt_r == '0) else $error("bit count not restarted");
  a_cmd_frame: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_valid |-> $past(cs_rise) && ($past(rise_cnt_r) == CNT_W'(CMD_SHORT_RISES)
      || $past(rise_cnt_r) == CNT_W'(CMD_LONG_RISES))) else $error("command from bad frame");
endmodule
